/* rtl/iod_decoder.v */
// instruction cycle decoder with its ahb-lite register slave
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "iod_map.vh"

// Notes on behaviour
// RULE1: every instruction cycle copies bus bits 18, 19, 20 into the tag register.
// RULE2: every instruction cycle loads the whole bus word into the storage register.
// RULE3: bits S, 1, 2 are decoded first; other loads wait on that result.
// RULE4: index-transfer codes load only held S, 8, 9 from bus S, 1, 2.
// RULE5: a sign bit of 1 means minus, 0 means plus.
// RULE6: all other instructions load bits S through 11 as the operation code.
// RULE7: first stage forms twelve terms from held bits 1 to 5.
// RULE8: second stage ands term pairs, bit 6 splits x2 from x3 groups.
// RULE9: code 00110 with bit 6 zero gives group 14, the overflow test branch.
// RULE10: group 40 splits into add or subtract by the held sign.
// RULE11: group outputs combine with held sign and bits 7, 8, 9.
// RULE12: group 76 ands with bits 6 to 9 into second decoder levels.
// RULE13: flags 12, 13 on an indexable non-7x op set indirect trigger at a4_d1.
// RULE14: the set trigger requests an indirect cycle; otherwise flags are ignored.
// RULE15: bit 18 sets the c tag latch at a3_d2, gating index register c.
// RULE16: bit 19 selects index register b, bit 20 a; no bit, none.
// RULE17: decoded and tag outputs hold until the next instruction load; indirect also clears on indirect_taken or ia_clr.
module iod_decoder #(
   parameter AW = 8,
   parameter XW = 18
) (
   // clock and reset
   input wire clock,
   input wire rstn,
   // ahb-lite slave
   input wire hsel,
   input wire [AW-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // storage bus and cycle timing
   input wire [0:35] storage_bus,
   input wire i_cycle,
   input wire sb_load,
   input wire a3_d2,
   input wire a4_d1,
   // execution control
   input wire indexable,
   input wire indirect_taken,
   // index registers a, b, c
   input wire [XW-1:0] index_register_a,
   input wire [XW-1:0] index_register_b,
   input wire [XW-1:0] index_register_c,
   // storage register toward the adder
   output reg [0:35] adder_operand,
   // decode results
   output reg decode_valid,
   output reg index_transfer,
   output reg held_sign_bit,
   output reg op_minus,
   output reg [11:0] first_terms,
   output reg [63:0] group,
   output reg [15:0] sod_level,
   output reg [7:0] low_select,
   output reg add_op,
   output reg sub_op,
   output reg overflow_test_branch,
   output reg [7:0] shift_count,
   // indexing and indirection
   output reg [2:0] tag_register,
   output reg [2:0] tag_latch,
   output reg [XW-1:0] index_out,
   output reg indirect_pending_trigger,
   output wire indirect_cycle
);

   // instruction holding register, sign at index 0
   reg [0:11] instruction_holding_register;
   reg [0:1] flag_bits;
   reg decode_en;
   reg load_seen;
   reg [31:0] cycle_count;

   // bus slave state
   reg wr_pend;
   reg [AW-1:0] wr_addr;
   reg ia_clr;

   wire [11:0] next_terms;
   wire [63:0] next_group;
   wire [15:0] next_sod;
   wire load;
   wire bus_xfer;
   wire addr_phase;
   wire group_7x;
   wire [5:0] group_code;
   // decoded strobes
   wire ia_set;
   wire wr_ctrl;
   reg [31:0] next_rdata;
   reg [XW-1:0] next_index;
   integer k;

   assign load = sb_load & i_cycle & decode_en;

   // sign, 1, 2 as +1, +-2 or +-3 marks an index transfer
   assign bus_xfer = storage_bus[1] |
      (~storage_bus[`IOD_BIT_SIGN] & storage_bus[2]); // RULE3 RULE5

   iod_first_decoder u_first_opcode_decoder (
      .code(instruction_holding_register[1:6]),
      .first_terms(next_terms),
      .group(next_group)
   );

   iod_second_decoder u_second_opcode_decoder (
      .group_76(next_group[`IOD_GRP_SECOND]),
      .code(instruction_holding_register[6:9]),
      .level(next_sod)
   );

   assign group_code = instruction_holding_register[1:6];
   // held bits 1 to 3 form the first octal digit of the group
   assign group_7x = (group_code[5:3] == `IOD_DIGIT_SEVEN);

   // word transfer and tag register, every instruction cycle
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         adder_operand <= `IOD_WORD_RST;
         tag_register <= 3'h0;
         cycle_count <= 32'h00000000;
      end else if (load) begin
         adder_operand <= storage_bus; // RULE2
         // latch order is c, b, a for bits 18, 19, 20
         tag_register <= {storage_bus[`IOD_BIT_TAG_C+2],
            storage_bus[`IOD_BIT_TAG_C+1],
            storage_bus[`IOD_BIT_TAG_C]}; // RULE1
         // only accepted loads are counted
         cycle_count <= cycle_count + 32'h00000001;
      end
   end

   // holding register, flags and shift counter
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         instruction_holding_register <= `IOD_HOLD_RST;
         flag_bits <= 2'h0;
         shift_count <= 8'h00;
         index_transfer <= 1'b0;
      end else if (load) begin
         index_transfer <= bus_xfer;
         if (bus_xfer) begin
            // only sign, 8 and 9 change for index transfers
            instruction_holding_register[0] <= storage_bus[0]; // RULE4
            instruction_holding_register[8] <= storage_bus[1]; // RULE4
            instruction_holding_register[9] <= storage_bus[2]; // RULE4
            // flags and shift count keep their older values
         end else begin
            instruction_holding_register <= storage_bus[0:11]; // RULE6
            flag_bits <= {storage_bus[`IOD_BIT_FLAG_HI],
               storage_bus[`IOD_BIT_FLAG_LO]};
            shift_count <= storage_bus[`IOD_BIT_SHIFT +: 8];
         end
      end
   end

   // registered decode outputs, one cycle after the holding register
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         load_seen <= 1'b0;
         decode_valid <= 1'b0;
         held_sign_bit <= 1'b0;
         op_minus <= 1'b0;
         first_terms <= 12'h000;
         group <= 64'h0000000000000000;
         sod_level <= 16'h0000;
         low_select <= 8'h00;
         add_op <= 1'b0;
         sub_op <= 1'b0;
         overflow_test_branch <= 1'b0;
      end else begin
         load_seen <= load;
         // valid is low for the one cycle the decoders settle
         if (load) begin
            decode_valid <= 1'b0;
         end else if (load_seen) begin
            decode_valid <= 1'b1; // RULE17
            held_sign_bit <= instruction_holding_register[0];
            op_minus <= instruction_holding_register[0]; // RULE5
            first_terms <= next_terms; // RULE7
            group <= next_group; // RULE8
            sod_level <= next_sod; // RULE12
            for (k = 0; k < 8; k = k + 1) begin
               low_select[k] <=
                  (instruction_holding_register[7:9] == k[2:0]); // RULE11
            end
            add_op <= next_group[`IOD_GRP_ADDSUB] &
               ~instruction_holding_register[0]; // RULE10
            sub_op <= next_group[`IOD_GRP_ADDSUB] &
               instruction_holding_register[0]; // RULE10
            overflow_test_branch <= next_group[`IOD_GRP_OVERFLOW]; // RULE9
         end
      end
   end

   // tag latches: cleared on load, set in the late cycle at a3_d2
   // a set in the same cycle as a clearing load wins
   genvar t;
   generate
      for (t = 0; t < 3; t = t + 1) begin : g_tag
         always @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               tag_latch[t] <= 1'b0;
            end else if (i_cycle & a3_d2 & tag_register[t]) begin
               tag_latch[t] <= 1'b1; // RULE15 RULE16
            end else if (load) begin
               tag_latch[t] <= 1'b0; // RULE17
            end
         end
      end
   endgenerate

   // index register gating, latch 0 is c, 1 is b, 2 is a
   // two set tags or their registers together
   always @* begin
      next_index = {XW{1'b0}};
      if (tag_latch[0]) begin
         next_index = next_index | index_register_c; // RULE15
      end
      if (tag_latch[1]) begin
         next_index = next_index | index_register_b; // RULE16
      end
      if (tag_latch[2]) begin
         next_index = next_index | index_register_a; // RULE16
      end
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         index_out <= {XW{1'b0}};
      end else begin
         index_out <= next_index;
      end
   end

   // indirect pending trigger; a set wins over a clear
   assign ia_set = i_cycle & a4_d1 & ~index_transfer & indexable &
      flag_bits[0] & flag_bits[1] & ~group_7x; // RULE13 RULE14

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         indirect_pending_trigger <= 1'b0;
      end else if (ia_set) begin
         indirect_pending_trigger <= 1'b1; // RULE13
      end else if (indirect_taken | ia_clr | load) begin
         indirect_pending_trigger <= 1'b0; // RULE17
      end
   end

   assign indirect_cycle = indirect_pending_trigger; // RULE14

   // ahb-lite slave, zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_phase = hsel & hready & htrans[1];
   // transfer size is not decoded, every register is one whole word
   assign wr_ctrl = wr_pend & (wr_addr == `IOD_OFF_CTRL);

   always @* begin
      next_rdata = 32'h00000000;
      case (haddr)
         `IOD_OFF_CTRL: begin
            next_rdata[`IOD_CTRL_EN] = decode_en;
         end
         `IOD_OFF_STATUS: begin
            next_rdata[`IOD_ST_TAG+2:`IOD_ST_TAG] = tag_register;
            next_rdata[`IOD_ST_LATCH+2:`IOD_ST_LATCH] = tag_latch;
            next_rdata[`IOD_ST_IA] = indirect_pending_trigger;
            next_rdata[`IOD_ST_XFER] = index_transfer;
            next_rdata[`IOD_ST_SIGN] = held_sign_bit;
            next_rdata[`IOD_ST_VALID] = decode_valid;
         end
         `IOD_OFF_HOLD: begin
            next_rdata[11:0] = instruction_holding_register;
         end
         `IOD_OFF_GROUP: begin
            next_rdata[`IOD_GR_CODE+5:`IOD_GR_CODE] = group_code;
            next_rdata[`IOD_GR_TERMS+11:`IOD_GR_TERMS] = first_terms;
         end
         `IOD_OFF_SR_LO: begin
            next_rdata = adder_operand[4:35];
         end
         `IOD_OFF_SR_HI: begin
            next_rdata[3:0] = adder_operand[0:3];
         end
         `IOD_OFF_SHIFT: begin
            next_rdata[7:0] = shift_count;
         end
         `IOD_OFF_COUNT: begin
            next_rdata = cycle_count;
         end
         // unmapped offsets read as zero
         default: begin
            next_rdata = 32'h00000000;
         end
      endcase
   end

   // read data is sampled at the address phase edge
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hrdata <= 32'h00000000;
         wr_pend <= 1'b0;
         wr_addr <= {AW{1'b0}};
      end else begin
         wr_pend <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr <= haddr;
            if (!hwrite) begin
               hrdata <= next_rdata;
            end
         end
      end
   end

   // write data phase
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         decode_en <= `IOD_CTRL_EN_RST;
         ia_clr <= 1'b0;
      end else begin
         ia_clr <= 1'b0;
         if (wr_ctrl) begin
            decode_en <= hwdata[`IOD_CTRL_EN];
            ia_clr <= hwdata[`IOD_CTRL_IACLR];
         end
      end
   end

endmodule

`default_nettype wire

/* rtl/iod_first_decoder.v */
// first opcode decoder: twelve first-stage terms and 64 group outputs
`timescale 1ns/1ps
`default_nettype none

module iod_first_decoder (
   // held operation code bits 1 to 6
   input wire [1:6] code,
   // first-stage terms: [7:0] digit 0x..7x, [11:8] pairs x0..x6
   output wire [11:0] first_terms,
   // second-stage groups, index is the octal group number
   output wire [63:0] group
);

   genvar i;

   generate
      for (i = 0; i < 8; i = i + 1) begin : g_digit
         assign first_terms[i] = (code[1:3] == i[2:0]); // RULE7
      end
      for (i = 0; i < 4; i = i + 1) begin : g_pair
         assign first_terms[8+i] = (code[4:5] == i[1:0]); // RULE7
      end
      for (i = 0; i < 64; i = i + 1) begin : g_group
         // bit 6 splits each pair into its even and odd group
         assign group[i] = first_terms[i/8] & first_terms[8+(i%8)/2] &
            (i[0] ? code[6] : ~code[6]); // RULE8 RULE9
      end
   endgenerate

endmodule

`default_nettype wire

/* rtl/iod_map.vh */
// register map and field constants for the instruction decoder
`ifndef IOD_MAP_VH
`define IOD_MAP_VH

// register byte offsets
`define IOD_OFF_CTRL 8'h00
`define IOD_OFF_STATUS 8'h04
`define IOD_OFF_HOLD 8'h08
`define IOD_OFF_GROUP 8'h0c
`define IOD_OFF_SR_LO 8'h10
`define IOD_OFF_SR_HI 8'h14
`define IOD_OFF_SHIFT 8'h18
`define IOD_OFF_COUNT 8'h1c

// control register fields
`define IOD_CTRL_EN 0
`define IOD_CTRL_IACLR 1
`define IOD_CTRL_EN_RST 1'b1

// status register fields
`define IOD_ST_TAG 0
`define IOD_ST_LATCH 3
`define IOD_ST_IA 6
`define IOD_ST_XFER 7
`define IOD_ST_SIGN 8
`define IOD_ST_VALID 9

// group register fields
`define IOD_GR_CODE 0
`define IOD_GR_TERMS 6

// instruction word bit positions, sign is bit 0
`define IOD_BIT_SIGN 0
`define IOD_BIT_FLAG_HI 12
`define IOD_BIT_FLAG_LO 13
`define IOD_BIT_TAG_C 18
`define IOD_BIT_SHIFT 28

// decoder groups
`define IOD_GRP_OVERFLOW 6'o14
`define IOD_GRP_ADDSUB 6'o40
`define IOD_GRP_SECOND 6'o76
`define IOD_DIGIT_SEVEN 3'o7

// reset values
`define IOD_WORD_RST 36'h000000000
`define IOD_HOLD_RST 12'h000

`endif

/* rtl/iod_second_decoder.v */
// second opcode decoder: sixteen levels inside group 76
`timescale 1ns/1ps
`default_nettype none

module iod_second_decoder (
   // group 76 term from the first decoder
   input wire group_76,
   // held bits 6 to 9
   input wire [6:9] code,
   // one level per value of bits 6 to 9
   output wire [15:0] level
);

   genvar i;

   generate
      for (i = 0; i < 16; i = i + 1) begin : g_level
         assign level[i] = group_76 & (code == i[3:0]); // RULE12
      end
   endgenerate

endmodule

`default_nettype wire

/* testbench/iod_assertions.sv */
// concurrent checks on the decoder ports
`timescale 1ns/1ps
`default_nettype none
`include "iod_map.vh"
module iod_assertions (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // storage bus side
   input wire logic [0:35] storage_bus,
   input wire logic i_cycle,
   input wire logic sb_load,
   input wire logic a3_d2,
   input wire logic a4_d1,
   input wire logic indexable,
   // register bus, to follow the load enable
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   // decode results
   input wire logic [0:35] adder_operand,
   input wire logic decode_valid,
   input wire logic index_transfer,
   input wire logic held_sign_bit,
   input wire logic [63:0] group,
   input wire logic add_op,
   input wire logic [7:0] shift_count,
   input wire logic [2:0] tag_register,
   input wire logic [2:0] tag_latch,
   input wire logic indirect_pending_trigger
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic en, ctrl_wr;
   // model of the load enable bit in the control register
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         en <= `IOD_CTRL_EN_RST;
         ctrl_wr <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            en <= hwdata[`IOD_CTRL_EN];
         end
         ctrl_wr <= hsel && htrans[1] && hwrite && haddr == `IOD_OFF_CTRL;
      end
   end
   wire logic ld = sb_load & i_cycle & en;
   wire logic xf = storage_bus[1] | (storage_bus[2] & !storage_bus[0]);
   sequence s_drop;
      !decode_valid;
   endsequence
   sequence s_ready;
      decode_valid && group == 64'h1 << $past(storage_bus[1:6], 2);
   endsequence
   AST_TAG: assert property (ld |=> tag_register ==
      $past({storage_bus[20], storage_bus[19], storage_bus[18]}))
      else $error("tag register not loaded");
   AST_SR: assert property (ld |=> adder_operand == $past(storage_bus))
      else $error("storage register not loaded");
   AST_XFER: assert property (ld |=> index_transfer == $past(xf))
      else $error("index transfer class wrong");
   AST_SHIFT: assert property (ld && xf |=> $stable(shift_count))
      else $error("shift count changed on index transfer");
   AST_DEC: assert property (ld && !xf |=> s_drop ##1 s_ready)
      else $error("group decode wrong");
   AST_ADD: assert property (decode_valid |->
      add_op == (group[`IOD_GRP_ADDSUB] & !held_sign_bit))
      else $error("add decode wrong");
   AST_TAGL: assert property (a3_d2 && i_cycle |=>
      tag_latch == $past(tag_register))
      else $error("tag latch wrong");
   AST_IA: assert property (a4_d1 && i_cycle && indexable &&
      adder_operand[12] && adder_operand[13] && !index_transfer &&
      group[63:56] == 8'h0 |=> indirect_pending_trigger)
      else $error("indirect trigger not set");
   AST_HOLD: assert property (!ld |=> $stable(adder_operand) &&
      $stable(tag_register))
      else $error("held outputs changed");
endmodule
bind iod_decoder iod_assertions i_chk (.clock(clock), .rstn(rstn),
   .storage_bus(storage_bus), .i_cycle(i_cycle), .sb_load(sb_load),
   .a3_d2(a3_d2), .a4_d1(a4_d1), .indexable(indexable),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata),
   .adder_operand(adder_operand), .decode_valid(decode_valid),
   .index_transfer(index_transfer), .held_sign_bit(held_sign_bit),
   .group(group), .add_op(add_op), .shift_count(shift_count),
   .tag_register(tag_register), .tag_latch(tag_latch),
   .indirect_pending_trigger(indirect_pending_trigger));
`default_nettype wire

/* testbench/iod_cpu_model.sv */
// storage bus and cycle timing model for the decoder
`timescale 1ns/1ps
`default_nettype none
module iod_cpu_model (
   // clock and request
   input wire logic clock,
   input wire logic go,
   input wire logic [0:35] word,
   // toward the decoder
   output logic [0:35] storage_bus,
   output logic i_cycle,
   output logic sb_load,
   output logic a3_d2,
   output logic a4_d1,
   output logic busy
);
   logic [2:0] st;
   initial {st, storage_bus, i_cycle, sb_load, a3_d2, a4_d1} = '0;
   assign busy = st != 3'h0;
   // load, then late pulses, then the bus word is inverted
   always @(posedge clock) begin
      sb_load <= go && st == 3'h0;
      a3_d2 <= st == 3'h2;
      a4_d1 <= st == 3'h3;
      i_cycle <= st == 3'h0 ? go : st < 3'h4;
      if (go && st == 3'h0) begin
         storage_bus <= word;
      end
      if (st == 3'h4) begin
         storage_bus <= ~storage_bus;
      end
      if (st != 3'h0 || go) begin
         st <= st == 3'h5 ? 3'h0 : st + 3'h1;
      end
   end
endmodule
`default_nettype wire

/* testbench/iod_decoder_tb.sv */
// self-checking bench of the instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "iod_map.vh"
module iod_decoder_tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic go = 1'b0;
   logic indexable = 1'b0;
   logic indirect_taken = 1'b0;
   logic [7:0] haddr = 8'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [0:35] word = 36'h0;
   logic [17:0] xa = 18'h0, xb = 18'h0, xc = 18'h0;
   logic [31:0] seed = 32'h172dc;
   logic [0:11] hold = 12'h0;
   logic [7:0] sh = 8'h0;
   int num_errors = 0;
   int checks = 0;
   wire logic hready, i_cycle, sb_load, a3_d2, a4_d1, busy;
   wire logic add, sub, ovf, icyc, om, hresp;
   wire logic [0:35] storage_bus, ao;
   wire logic [31:0] hrdata;
   wire logic [63:0] grp;
   wire logic [15:0] second_opcode_decoder;
   wire logic [11:0] ft;
   wire logic [7:0] lsel;
   wire logic [17:0] xo;
   iod_cpu_model i_cpu (.clock(clock), .go(go), .word(word),
      .storage_bus(storage_bus), .i_cycle(i_cycle), .sb_load(sb_load),
      .a3_d2(a3_d2), .a4_d1(a4_d1), .busy(busy));
   iod_decoder i_dut (.clock(clock), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .storage_bus(storage_bus),
      .i_cycle(i_cycle), .sb_load(sb_load), .a3_d2(a3_d2),
      .a4_d1(a4_d1), .indexable(indexable),
      .indirect_taken(indirect_taken), .index_register_a(xa),
      .index_register_b(xb), .index_register_c(xc),
      .adder_operand(ao), .decode_valid(), .index_transfer(),
      .held_sign_bit(), .op_minus(om), .first_terms(ft), .group(grp),
      .sod_level(second_opcode_decoder), .low_select(lsel), .add_op(add), .sub_op(sub),
      .overflow_test_branch(ovf), .shift_count(), .tag_register(),
      .tag_latch(), .index_out(xo), .indirect_pending_trigger(),
      .indirect_cycle(icyc));
   always #25 clock = ~clock;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clock); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      check({hresp, r}, {1'b0, e});
   endtask
   task automatic run(input logic [0:35] w, input logic ix);
      logic xf, tr, ad;
      logic [2:0] tg;
      logic [31:0] r;
      xf = w[1] | (w[2] & !w[0]);
      if (xf) begin
         hold[0] = w[0];
         hold[8:9] = w[1:2];
      end else begin
         hold = w[0:11];
         sh = w[28:35];
      end
      tg = {w[20], w[19], w[18]};
      tr = !xf & w[12] & w[13] & ix & hold[1:3] != 3'h7;
      ad = hold[1:6] == `IOD_GRP_ADDSUB;
      r = rnd();
      @(posedge clock);
      word <= w;
      indexable <= ix;
      go <= 1'b1;
      xa <= r[17:0];
      xb <= r[27:10];
      xc <= {r[31:28], r[13:0]};
      @(posedge clock);
      go <= 1'b0;
      do begin
         @(posedge clock);
         #1;
      end while (a4_d1 !== 1'b1);
      @(posedge clock);
      #1;
      check(ao, w);
      check(grp, 64'h1 << hold[1:6]);
      check(ft, {4'h1 << hold[4:5], 8'h1 << hold[1:3]});
      check(second_opcode_decoder, hold[1:6] == `IOD_GRP_SECOND ? 16'h1 << hold[6:9] : 0);
      check(lsel, 8'h1 << hold[7:9]);
      check({add, sub, ovf, om}, {ad & !hold[0], ad & hold[0],
         hold[1:6] == `IOD_GRP_OVERFLOW, hold[0]});
      check(xo, ({18{tg[0]}} & xc) | ({18{tg[1]}} & xb) |
         ({18{tg[2]}} & xa));
      check(icyc, tr);
      while (busy) @(posedge clock);
      rd(`IOD_OFF_STATUS, {hold[0], xf, tr, tg, tg} | 32'h200);
      rd(`IOD_OFF_HOLD, {20'h0, hold});
      rd(`IOD_OFF_SHIFT, {24'h0, sh});
      rd(`IOD_OFF_GROUP, {4'h1 << hold[4:5], 8'h1 << hold[1:3],
         hold[1:6]});
      rd(`IOD_OFF_SR_LO, w[4:35]);
      rd(`IOD_OFF_SR_HI, w[0:3]);
      if (tr) begin
         if (r[0]) begin
            @(posedge clock);
            indirect_taken <= 1'b1;
            @(posedge clock);
            indirect_taken <= 1'b0;
         end else begin
            ahb(1'b1, `IOD_OFF_CTRL, 32'h3, r);
         end
         rd(`IOD_OFF_STATUS, {hold[0], xf, 1'b0, tg, tg} | 32'h200);
      end
   endtask
   initial begin
      #500000;
      num_errors++;
      finish_test();
   end
   initial begin
      logic [31:0] r;
      logic [0:35] w;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      rd(`IOD_OFF_CTRL, 32'h1);
      ahb(1'b1, `IOD_OFF_STATUS, 32'h3ff, r);
      rd(`IOD_OFF_STATUS, 32'h0);
      rd(8'h40, 32'h0);
      // a load while disabled must be refused
      ahb(1'b1, `IOD_OFF_CTRL, 32'h0, r);
      word <= '1;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (8) @(posedge clock);
      rd(`IOD_OFF_COUNT, 32'h0);
      rd(`IOD_OFF_SR_HI, 32'h0);
      ahb(1'b1, `IOD_OFF_CTRL, 32'h1, r);
      $display("register test done");
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         w = {r[3:0], rnd()};
         case (i % 8)
            0: w[1:6] = `IOD_GRP_OVERFLOW;
            1: w[0:6] = {1'b0, `IOD_GRP_ADDSUB};
            2: w[0:6] = {1'b1, `IOD_GRP_ADDSUB};
            3: w[0:2] = 3'h1;
            4: w[1:13] = {`IOD_GRP_SECOND, r[10:4] | 7'h03};
            5: w[1:13] = {3'h2, r[13:4] | 10'h003};
            6: w[0:2] = 3'h6;
            default: w[18:20] = 3'h0;
         endcase
         run(w, r[20] | i % 8 == 5);
      end
      rd(`IOD_OFF_COUNT, 32'h28);
      $display("instruction test done");
      finish_test();
   end
endmodule
`default_nettype wire
